// *** src/adcsq_params.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes inclusion by the package and the testbench.
 */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define ADCSQ_IDX_CSR        8'h2e
`define ADCSQ_IDX_RES_HIGH   8'h2f
`define ADCSQ_IDX_RES_LOW    8'h30
`define ADCSQ_IDX_CLK_CTRL   8'h31
`define ADCSQ_IDX_MODE       8'h32
`define ADCSQ_ADDR_CSR       (`ADCSQ_IDX_CSR * 4)
`define ADCSQ_ADDR_RES_HIGH  (`ADCSQ_IDX_RES_HIGH * 4)
`define ADCSQ_ADDR_RES_LOW   (`ADCSQ_IDX_RES_LOW * 4)
`define ADCSQ_ADDR_CLK_CTRL  (`ADCSQ_IDX_CLK_CTRL * 4)
`define ADCSQ_ADDR_MODE      (`ADCSQ_IDX_MODE * 4)

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCSQ_CSR_DONE_BIT   7
`define ADCSQ_CSR_DIV_HI     6
`define ADCSQ_CSR_DIV_LO     5
`define ADCSQ_CSR_ON_BIT     4
`define ADCSQ_CSR_CH_HI      3
`define ADCSQ_CSR_CH_LO      0
`define ADCSQ_CLK_IRQEN_BIT  0
`define ADCSQ_CLK_STRETCH_BIT 1
`define ADCSQ_MODE_WAIT_BIT  0
`define ADCSQ_MODE_HALT_BIT  1

// ----------------------------------------------------------------------------
// Reset values and result codes
// ----------------------------------------------------------------------------
`define ADCSQ_CSR_RESET      8'h00
`define ADCSQ_RES_RESET      8'h00
`define ADCSQ_FULL_HIGH      8'hff
`define ADCSQ_FULL_LOW       8'h03
`define ADCSQ_ZERO_CODE      10'h000

// ----------------------------------------------------------------------------
// Timing: core rate, converter rates, cycles per conversion
// ----------------------------------------------------------------------------
`define ADCSQ_CORE_HZ        40000000
`define ADCSQ_FADC_4M_HZ     4000000
`define ADCSQ_FADC_2M_HZ     2000000
`define ADCSQ_FADC_1M_HZ     1000000
`define ADCSQ_DIV_4M         (`ADCSQ_CORE_HZ / `ADCSQ_FADC_4M_HZ)
`define ADCSQ_DIV_2M         (`ADCSQ_CORE_HZ / `ADCSQ_FADC_2M_HZ)
`define ADCSQ_DIV_1M         (`ADCSQ_CORE_HZ / `ADCSQ_FADC_1M_HZ)
`define ADCSQ_CONV_TICKS     14
`define ADCSQ_STRETCH_TICKS  4

`endif

// *** src/adcsq_pkg.sv ***
/*
 * Types of the converter sequencer. Assumes adcsq_params.svh is on the
 * include path.
 */
package adcsq_pkg;
    `include "adcsq_params.svh"

    // Conversion sequencer states, one-hot
    typedef enum logic [2:0] {
        ADCSQ_IDLE   = 3'b001,
        ADCSQ_CONV   = 3'b010,
        ADCSQ_FINISH = 3'b100
    } adcsq_state_t;
endpackage

// *** src/adcsq_sequencer.sv ***
/*
 * APB-attached control and result logic of a 10-bit multiplexed converter:
 * channel select, continuous conversion, done flag, interrupt request,
 * prescaler, result saturation and the low/high read lock.
 * Assumes the analog core delivers a sampled 10-bit code plus over/under
 * range flags on clk, and that wait/halt levels come from the power manager.
 */
// Decided for this implementation: the APB slave port.
// Summary of operation
// - Input above high reference reads full scale ffh/03h, no overflow flag.
// - Input below low reference reads zero in both result registers.
// - Four-bit channel field N selects analog input N, zero to fifteen.
// - Setting converter_on starts continuous back-to-back conversion of the channel.
// - Clearing converter_on stops any conversion in progress.
// - Done flag stays set through the following conversions until the high register is read.
// - Completion sets done flag and loads results, valid until next finish.
// - Interrupt request per completion only when conversion_irq_enable is set.
// - Channel write mid-conversion abandons it and restarts on new channel.
// - Reading the high result register is the only clear of done flag.
// - Reading the low result register locks both result registers.
// - Lock releases on high register read or converter_on clear.
// - Locked results ignore completions until high register is read or converter_on is cleared.
// - Divider codes 00, 01, 10 give 4, 2 and 1 MHz converter clock.
// - High register shows bits 9..2, low register bits 1..0.
// - Low register bits 7..2 always read zero.
// - Control bit 7 read-only, rest read/write, register resets to zero.
// - Wait leaves conversion running; halt disables converter, no wake.
`timescale 1ns/1ps
`default_nettype none

module adcsq_sequencer
    import adcsq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  analogCode,
    input  wire logic        aboveHighRef,
    input  wire logic        belowLowRef,
    output logic      [3:0]  channelSel,
    output logic             sampleStart,
    output logic             converterPowered,
    output logic             convIrq,
    output logic             wakeFromWait
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0]   csrCtl_q;       // Bits 6:0 of the control/status register
    logic         doneFlag_q;
    logic [1:0]   clkCtl_q;       // Stretch and interrupt enable
    logic [1:0]   modeLvl_q;      // Halt and wait levels
    logic [9:0]   result_q;
    logic         locked_q;
    adcsq_state_t state_q;
    logic [5:0]   preCnt_q;
    logic [4:0]   tickCnt_q;
    logic         irqPulse_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic [3:0]   chanOut_q;
    logic         startOut_q;
    logic         powerOut_q;
    logic         wakeOut_q;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Access phase taken on the second penable cycle, after one wait state
    logic setupSeen;
    logic wrCsr;
    logic wrClk;
    logic wrMode;
    logic rdHigh;
    logic rdLow;
    logic mapped;
    logic converterOn;
    logic chanChange;
    logic convEnd;
    logic tickNow;

    function automatic logic hitAddr(input logic [11:0] a, input int unsigned byteAddr);
        hitAddr = (a == byteAddr[11:0]);
    endfunction

    // Prescaler reload per divider code
    function automatic logic [5:0] divReload(input logic [1:0] code);
        unique case (code)
            2'b00:   divReload = 6'(`ADCSQ_DIV_4M - 1);
            2'b01:   divReload = 6'(`ADCSQ_DIV_2M - 1);
            default: divReload = 6'(`ADCSQ_DIV_1M - 1);
        endcase
    endfunction

    // Access takes effect when pready is seen high with psel and penable
    assign setupSeen = psel && penable && pready_q;
    assign mapped    = hitAddr(paddr, `ADCSQ_ADDR_CSR) || hitAddr(paddr, `ADCSQ_ADDR_RES_HIGH)
                    || hitAddr(paddr, `ADCSQ_ADDR_RES_LOW) || hitAddr(paddr, `ADCSQ_ADDR_CLK_CTRL)
                    || hitAddr(paddr, `ADCSQ_ADDR_MODE);
    assign wrCsr     = setupSeen && pwrite && hitAddr(paddr, `ADCSQ_ADDR_CSR);
    assign wrClk     = setupSeen && pwrite && hitAddr(paddr, `ADCSQ_ADDR_CLK_CTRL);
    assign wrMode    = setupSeen && pwrite && hitAddr(paddr, `ADCSQ_ADDR_MODE);
    assign rdHigh    = setupSeen && !pwrite && hitAddr(paddr, `ADCSQ_ADDR_RES_HIGH);
    assign rdLow     = setupSeen && !pwrite && hitAddr(paddr, `ADCSQ_ADDR_RES_LOW);
    // Halt forces the converter off without touching the stored bit
    assign converterOn = csrCtl_q[`ADCSQ_CSR_ON_BIT] && !modeLvl_q[`ADCSQ_MODE_HALT_BIT];
    assign chanChange  = wrCsr && (pwdata[3:0] != csrCtl_q[3:0]);
    assign tickNow     = (preCnt_q == 6'h00);
    assign convEnd     = (state_q == ADCSQ_FINISH);

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Ready toggles in after one access cycle; unmapped addresses give pslverr
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q  <= 32'h0000_0000;
            if (!pwrite) begin
                if (hitAddr(paddr, `ADCSQ_ADDR_CSR)) begin
                    prdata_q[7:0] <= {doneFlag_q, csrCtl_q[6:0]};
                end else if (hitAddr(paddr, `ADCSQ_ADDR_RES_HIGH)) begin
                    prdata_q[7:0] <= result_q[9:2];
                end else if (hitAddr(paddr, `ADCSQ_ADDR_RES_LOW)) begin
                    prdata_q[7:0] <= {6'h00, result_q[1:0]};
                end else if (hitAddr(paddr, `ADCSQ_ADDR_CLK_CTRL)) begin
                    prdata_q[1:0] <= clkCtl_q;
                end else if (hitAddr(paddr, `ADCSQ_ADDR_MODE)) begin
                    prdata_q[1:0] <= modeLvl_q;
                end
            end
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Control bits 6:0 writable, bit 7 kept apart as the done flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csrCtl_q <= `ADCSQ_CSR_RESET;
        end else if (wrCsr) begin
            csrCtl_q <= {1'b0, pwdata[6:0]};
        end
    end

    // External clock-control and power-mode levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clkCtl_q  <= 2'b00;
            modeLvl_q <= 2'b00;
        end else begin
            if (wrClk) begin
                clkCtl_q <= pwdata[1:0];
            end
            if (wrMode) begin
                modeLvl_q <= pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Converter clock prescaler
    // ------------------------------------------------------------------------
    // Counts core clocks down to one converter tick, restarts with conversion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCnt_q <= 6'h00;
        end else if (!converterOn || chanChange || state_q != ADCSQ_CONV || tickNow) begin
            preCnt_q <= divReload(csrCtl_q[6:5]);
        end else begin
            preCnt_q <= preCnt_q - 6'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------------
    // Idle until on, count fixed ticks, finish one cycle, then restart
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q   <= ADCSQ_IDLE;
            tickCnt_q <= 5'h00;
        end else if (!converterOn) begin
            state_q   <= ADCSQ_IDLE;
            tickCnt_q <= 5'h00;
        end else if (chanChange) begin
            state_q   <= ADCSQ_CONV;
            tickCnt_q <= 5'h00;
        end else begin
            unique case (state_q)
                ADCSQ_IDLE: begin
                    state_q   <= ADCSQ_CONV;
                    tickCnt_q <= 5'h00;
                end
                ADCSQ_CONV: begin
                    if (tickNow) begin
                        // At-or-past compare, so a stretch clear mid-conversion cannot overrun
                        if (tickCnt_q >= 5'(`ADCSQ_CONV_TICKS - 1 + (clkCtl_q[1] ? `ADCSQ_STRETCH_TICKS : 0))) begin
                            state_q <= ADCSQ_FINISH;
                        end
                        tickCnt_q <= tickCnt_q + 5'h01;
                    end
                end
                ADCSQ_FINISH: begin
                    state_q   <= ADCSQ_CONV;
                    tickCnt_q <= 5'h00;
                end
                default: begin
                    state_q   <= ADCSQ_IDLE;
                    tickCnt_q <= 5'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Done flag, results and lock
    // ------------------------------------------------------------------------
    // Done flag: completion set wins over the high-register read clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            doneFlag_q <= 1'b0;
        end else if (convEnd) begin
            doneFlag_q <= 1'b1;
        end else if (rdHigh || state_q == ADCSQ_CONV && chanChange) begin
            doneFlag_q <= rdHigh ? 1'b0 : doneFlag_q;
        end
    end

    // Lock set by low read, released by high read or converter_on bit clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            locked_q <= 1'b0;
        end else if (rdHigh || !csrCtl_q[`ADCSQ_CSR_ON_BIT]) begin
            locked_q <= 1'b0;
        end else if (rdLow) begin
            locked_q <= 1'b1;
        end
    end

    // Result loads on completion unless locked; range saturation applied
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_q <= {`ADCSQ_RES_RESET, 2'b00};
        end else if (convEnd && !locked_q) begin
            if (aboveHighRef) begin
                result_q <= {`ADCSQ_FULL_HIGH, 2'(`ADCSQ_FULL_LOW)};
            end else if (belowLowRef) begin
                result_q <= `ADCSQ_ZERO_CODE;
            end else begin
                result_q <= analogCode;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs toward the analog core and interrupt controller
    // ------------------------------------------------------------------------
    // All registered; irq is a one-cycle pulse per completion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqPulse_q <= 1'b0;
            wakeOut_q  <= 1'b0;
            chanOut_q  <= 4'h0;
            startOut_q <= 1'b0;
            powerOut_q <= 1'b0;
        end else begin
            irqPulse_q <= convEnd && clkCtl_q[`ADCSQ_CLK_IRQEN_BIT];
            wakeOut_q  <= convEnd && clkCtl_q[`ADCSQ_CLK_IRQEN_BIT]
                          && modeLvl_q[`ADCSQ_MODE_WAIT_BIT];
            chanOut_q  <= csrCtl_q[3:0];
            startOut_q <= converterOn && state_q == ADCSQ_CONV && tickCnt_q == 5'h00 && tickNow;
            powerOut_q <= converterOn;
        end
    end

    assign convIrq          = irqPulse_q;
    assign wakeFromWait     = wakeOut_q;
    assign channelSel       = chanOut_q;
    assign sampleStart      = startOut_q;
    assign converterPowered = powerOut_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_FULL_SCALE: assert property (convEnd && !locked_q && aboveHighRef |=> result_q == 10'h3ff)
        else $error("full scale code not loaded");
    AST_ZERO: assert property (convEnd && !locked_q && !aboveHighRef && belowLowRef |=> result_q == 10'h000)
        else $error("zero code not loaded");
    AST_CHANNEL: assert property (wrCsr |=> ##1 channelSel == $past(pwdata[3:0], 2))
        else $error("channel output does not follow field");
    AST_START: assert property ($rose(converterOn) |=> state_q == ADCSQ_CONV)
        else $error("conversion did not start");
    AST_STOP: assert property (!converterOn |=> state_q == ADCSQ_IDLE)
        else $error("conversion not stopped");
    AST_DONE_SET: assert property (convEnd |=> doneFlag_q)
        else $error("done flag not set");
    AST_IRQ: assert property (convEnd |=> convIrq == $past(clkCtl_q[0]))
        else $error("irq not gated by enable");
    AST_RESTART: assert property (converterOn && chanChange |=> state_q == ADCSQ_CONV && tickCnt_q == 5'h00)
        else $error("channel change did not restart");
    AST_CLEAR: assert property (rdHigh && !convEnd |=> !doneFlag_q)
        else $error("high read did not clear flag");
    AST_LOCK: assert property (locked_q && convEnd |=> $stable(result_q))
        else $error("locked result overwritten");
    AST_UNLOCK: assert property (rdHigh |=> !locked_q)
        else $error("lock not released");
    AST_LOW_ZERO: assert property (rdLow |-> prdata[7:2] == 6'h00)
        else $error("low register upper bits nonzero");

    // Wake, halt, plain result loading and back-to-back restart
    AST_WAKE: assert property (convEnd && clkCtl_q[`ADCSQ_CLK_IRQEN_BIT] && modeLvl_q[`ADCSQ_MODE_WAIT_BIT] |=> wakeFromWait)
        else $error("no wake request in wait");
    AST_HALT: assert property (modeLvl_q[`ADCSQ_MODE_HALT_BIT] |=> !converterPowered)
        else $error("converter powered in halt");
    AST_RESULT: assert property (convEnd && !locked_q && !aboveHighRef && !belowLowRef |=> result_q == $past(analogCode))
        else $error("in-range code not loaded");
    AST_FINISH_ONE: assert property (convEnd && converterOn |=> state_q == ADCSQ_CONV && tickCnt_q == 5'h00)
        else $error("no restart after completion");

    // ------------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------------
    // Main scenarios reached
    COV_DONE: cover property (convEnd ##[1:40] rdHigh);
    COV_LOCKED_END: cover property (locked_q && convEnd);
    COV_RESTART: cover property (state_q == ADCSQ_CONV && chanChange);
    COV_STRETCH: cover property (convEnd && clkCtl_q[`ADCSQ_CLK_STRETCH_BIT]);
    COV_WAKE: cover property (wakeFromWait);

endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
/*
 * Self-checking bench of the converter sequencer: APB register access,
 * continuous conversion, result format, done flag, read lock, prescaler,
 * channel restart, interrupt gating, wait and halt.
 * Assumes adcsq_pkg and adcsq_params.svh compiled first; clock 40 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin errCount++; \
    $display("[ERR] %s exp=%h got=%h", nm, ex, gt); end end

module tb_top
    import adcsq_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk, rst_n, psel, penable, pwrite, pslverr, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdQ;
    logic [9:0]  analogCode;
    logic        aboveHighRef, belowLowRef, sampleStart, converterPowered, convIrq, wakeFromWait;
    logic [3:0]  channelSel;
    logic [31:0] rngQ;
    int          errCount, nTests, cyc, irqCnt, wakeCnt, lastIrq, prevIrq, startCnt;
    logic        errQ;

    adcsq_sequencer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analogCode(analogCode), .aboveHighRef(aboveHighRef), .belowLowRef(belowLowRef),
        .channelSel(channelSel), .sampleStart(sampleStart), .converterPowered(converterPowered),
        .convIrq(convIrq), .wakeFromWait(wakeFromWait));

    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cycle count and completion pulse log
    always @(posedge clk) begin
        cyc++;
        if (convIrq === 1'b1) begin
            irqCnt++;
            prevIrq = lastIrq;
            lastIrq = cyc;
        end
        if (wakeFromWait === 1'b1) wakeCnt++;
        if (sampleStart === 1'b1) startCnt++;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Expected high and low result bytes
    function automatic logic [7:0] expHi(input logic [9:0] c, input logic hi, input logic lo);
        return hi ? `ADCSQ_FULL_HIGH : lo ? 8'h00 : c[9:2];
    endfunction
    function automatic logic [7:0] expLo(input logic [9:0] c, input logic hi, input logic lo);
        return hi ? `ADCSQ_FULL_LOW : lo ? 8'h00 : {6'h00, c[1:0]};
    endfunction

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input int a, input logic [7:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= 12'(a); pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) errCount++;
        rdQ = prdata;
        errQ = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic waitIrq(input int n);
        int c0, i;
        c0 = irqCnt;
        i = 0;
        while (irqCnt < c0 + n && i < 3000) begin
            @(posedge clk);
            i++;
        end
        if (i >= 3000) errCount++;
    endtask

    task automatic final_report();
        if (errCount == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Convert code c (flags h,l) and check both result bytes read low then high
    task automatic convCheck(input logic [9:0] c, input logic h, input logic l);
        analogCode <= c; aboveHighRef <= h; belowLowRef <= l;
        waitIrq(2);
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("doneSet", 1'b1, rdQ[7])
        apb(1'b0, `ADCSQ_ADDR_RES_LOW, 8'h00);
        `CHK("resLow", {24'h0, expLo(c, h, l)}, rdQ)
        apb(1'b0, `ADCSQ_ADDR_RES_HIGH, 8'h00);
        `CHK("resHigh", {24'h0, expHi(c, h, l)}, rdQ)
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("doneClr", 1'b0, rdQ[7])
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge clk);
        errCount++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int c, p, t0;
        int divTab [3] = '{10, 20, 40};
        logic [9:0] a;
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        analogCode = 10'h000; aboveHighRef = 1'b0; belowLowRef = 1'b0; rngQ = 32'd864;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and unmapped access
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("csrReset", 32'h0, rdQ)
        apb(1'b0, `ADCSQ_ADDR_RES_HIGH, 8'h00);
        `CHK("highReset", 32'h0, rdQ)
        apb(1'b0, `ADCSQ_ADDR_RES_LOW, 8'h00);
        `CHK("lowReset", 32'h0, rdQ)
        apb(1'b0, 12'h100, 8'h00);
        `CHK("unmapped", 1'b1, errQ)
        // Bit 7 read-only, others read/write
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'hef);
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("csrRw", 32'h6f, rdQ)
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h00);
        apb(1'b1, `ADCSQ_ADDR_CLK_CTRL, 8'h01);
        // Random conversions over random channels, corner ranges first
        for (int k = 0; k < 7; k++) begin
            rngQ = xs(rngQ);
            apb(1'b1, `ADCSQ_ADDR_CSR, {4'h1, rngQ[3:0]});
            repeat (3) @(posedge clk);
            `CHK("channelSel", rngQ[3:0], channelSel)
            `CHK("powered", 1'b1, converterPowered)
            convCheck(rngQ[13:4], k == 0, k == 1);
        end
        // Prescaler codes: completion period
        for (int d = 0; d < 3; d++) begin
            apb(1'b1, `ADCSQ_ADDR_CSR, {1'b0, 2'(d), 1'b1, 4'h5});
            waitIrq(3);
            p = lastIrq - prevIrq;
            `CHK("period", 1'b1, p >= 14 * divTab[d] && p <= 15 * divTab[d] + 4)
        end
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h15);
        // Stretched sampling, one start per conversion, 8-bit read of high only
        apb(1'b1, `ADCSQ_ADDR_CLK_CTRL, 8'h03);
        waitIrq(1);
        t0 = startCnt;
        waitIrq(2);
        p = lastIrq - prevIrq;
        `CHK("stretch", 1'b1, p >= 18 * divTab[0] && p <= 19 * divTab[0])
        `CHK("starts", 2, startCnt - t0)
        apb(1'b0, `ADCSQ_ADDR_RES_HIGH, 8'h00);
        `CHK("high8", {24'h0, expHi(analogCode, 1'b0, 1'b0)}, rdQ)
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("done8Clr", 1'b0, rdQ[7])
        apb(1'b1, `ADCSQ_ADDR_CLK_CTRL, 8'h01);
        // Lock on low read holds results until high read
        rngQ = xs(rngQ);
        a = rngQ[9:0];
        convCheck(a, 1'b0, 1'b0);
        apb(1'b0, `ADCSQ_ADDR_RES_LOW, 8'h00);
        analogCode <= ~a;
        waitIrq(2);
        apb(1'b0, `ADCSQ_ADDR_RES_HIGH, 8'h00);
        `CHK("lockHigh", {24'h0, a[9:2]}, rdQ)
        waitIrq(1);
        apb(1'b0, `ADCSQ_ADDR_RES_LOW, 8'h00);
        `CHK("unlockLow", {24'h0, 6'h00, ~a[1:0]}, rdQ)
        // Lock released by clearing converter_on
        analogCode <= a;
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h05);
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h15);
        waitIrq(2);
        apb(1'b0, `ADCSQ_ADDR_RES_LOW, 8'h00);
        `CHK("onClrUnlock", {24'h0, 6'h00, a[1:0]}, rdQ)
        apb(1'b0, `ADCSQ_ADDR_RES_HIGH, 8'h00);
        // Channel change mid-conversion restarts it
        waitIrq(1);
        repeat (70) @(posedge clk);
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h1a);
        t0 = cyc;
        waitIrq(1);
        `CHK("restart", 1'b1, lastIrq - t0 >= 140)
        `CHK("newChannel", 4'ha, channelSel)
        // Interrupt request gated by enable
        apb(1'b1, `ADCSQ_ADDR_CLK_CTRL, 8'h00);
        c = irqCnt;
        repeat (400) @(posedge clk);
        `CHK("irqMasked", c, irqCnt)
        apb(1'b0, `ADCSQ_ADDR_CSR, 8'h00);
        `CHK("doneNoIrq", 1'b1, rdQ[7])
        apb(1'b1, `ADCSQ_ADDR_CLK_CTRL, 8'h01);
        // Wait mode keeps converting and wakes
        apb(1'b1, `ADCSQ_ADDR_MODE, 8'h01);
        c = wakeCnt;
        waitIrq(1);
        @(posedge clk);
        `CHK("wake", c + 1, wakeCnt)
        // Halt disables converter
        apb(1'b1, `ADCSQ_ADDR_MODE, 8'h02);
        repeat (3) @(posedge clk);
        `CHK("haltOff", 1'b0, converterPowered)
        c = irqCnt;
        repeat (400) @(posedge clk);
        `CHK("haltNoIrq", c, irqCnt)
        apb(1'b1, `ADCSQ_ADDR_MODE, 8'h00);
        // Clearing converter_on stops conversion
        apb(1'b1, `ADCSQ_ADDR_CSR, 8'h0a);
        c = irqCnt;
        repeat (400) @(posedge clk);
        `CHK("offNoIrq", c, irqCnt)
        `CHK("offPower", 1'b0, converterPowered)
        final_report();
    end
endmodule
`default_nettype wire
